/* verilog/ppr_top.sv */
// Behaviour
// R1: Drive the assigned data line throughout identify, outside any handshake.
// R2: Capture instrument status when identify starts; later changes ignored.
// R3: When identify ends, release all eight data lines.
// R4: Once configured, answer every identify with current status, no reconfigure.
// R5: Controller reassigns by listen address, configure, disable, then enable.
// R6: Disable, unconfigure or master reset clear assignment; interface clear does not.
// R7: Unconfigure, reset or configure-disable return to idle, ignoring identify.
// R8: System supplies the device clock at the intended rate.
// R9: Enable byte low three bits pick the line, fourth bit is sense.
// R10: Configure while listening arms enable; unlisten stops further enables.
// R11: Identify is end-or-identify with attention; drive when status matches sense.
//
// Chosen here: the address map and the Wishbone register port.
`timescale 1ns/10ps
`default_nettype none
module ppr_top #(
  parameter int DIO_W = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Classic Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o,
  // From the acceptor and addressing logic, same clock
  input wire ppr_pkg::ppr_cmd_s cmd_i,
  input wire logic listen_addressed_i,
  // Pins
  input wire logic atn_n_i,
  input wire logic eoi_n_i,
  input wire logic master_reset_n_i,
  input wire logic instrument_status_bit_i,
  output logic [DIO_W-1:0] dio_o,
  output logic [DIO_W-1:0] dio_oe_o
);
  if (DIO_W != 8)
  begin : g_bad_width
    $error("ppr_top: DIO_W must be 8");
  end
  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [3:0] sync1_reg;
  logic [3:0] sync2_reg;
  logic [3:0] sync1_next;
  logic [3:0] sync2_next;
  logic atn_s;
  logic eoi_s;
  logic mr_n_s;
  logic ist_s;
  // First stage read only by the second
  always_comb
  begin
    sync1_next = {instrument_status_bit_i, master_reset_n_i, eoi_n_i, atn_n_i};
    sync2_next = sync1_reg;
  end
  // ATN, EOI and master reset idle high, so reset to the passive level; the status bit resets low
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sync1_reg <= 4'h7;
      sync2_reg <= 4'h7;
    end
    else if (ce_i)
    begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
    end
  end
  assign atn_s = sync2_reg[0];
  assign eoi_s = sync2_reg[1];
  assign mr_n_s = sync2_reg[2];
  assign ist_s = sync2_reg[3];
  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  function automatic logic is_hi(input logic [7:0] b, input logic [3:0] hi);
    is_hi = (b[7:4] == hi);
  endfunction
  logic identify;
  logic is_ppc;
  logic is_ppu;
  logic is_ppe;
  logic is_ppd;
  logic is_unl;
  // R11: identify decode
  assign identify = ~eoi_s & ~atn_s;
  assign is_ppc = cmd_i.valid & (cmd_i.byte_val == ppr_pkg::CMD_PPC);
  assign is_ppu = cmd_i.valid & (cmd_i.byte_val == ppr_pkg::CMD_PPU);
  assign is_unl = cmd_i.valid & (cmd_i.byte_val == ppr_pkg::CMD_UNL);
  assign is_ppe = cmd_i.valid & is_hi(cmd_i.byte_val, ppr_pkg::CMD_PPE_HI);
  assign is_ppd = cmd_i.valid & is_hi(cmd_i.byte_val, ppr_pkg::CMD_PPD_HI);
  // ----------------------------------------------------------------
  // Poll state
  // ----------------------------------------------------------------
  ppr_pkg::ppr_state_e state_reg;
  ppr_pkg::ppr_state_e state_next;
  logic armed_reg;
  logic armed_next;
  logic [3:0] assign_reg;
  logic [3:0] assign_next;
  logic latched_reg;
  logic latched_next;
  logic resp_en_reg;
  logic resp_en_next;
  logic unconf_pulse;
  logic clear_all;
  // Interface clear is deliberately not an input here: it must not clear us
  // R6: assignment clear sources
  assign clear_all = ~mr_n_s | is_ppu | unconf_pulse;
  // Next state of the configuration and response machine
  always_comb
  begin
    state_next = state_reg;
    armed_next = armed_reg;
    assign_next = assign_reg;
    latched_next = latched_reg;
    // R10: arm on configure while listening, disarm on unlisten
    if (is_unl || !listen_addressed_i)
    begin
      armed_next = 1'b0;
    end
    else if (is_ppc)
    begin
      armed_next = 1'b1;
    end
    case (state_reg)
      ppr_pkg::PP_IDLE:
      begin
        // R9: take line select and sense from enable byte
        if (armed_reg && listen_addressed_i && is_ppe)
        begin
          assign_next = cmd_i.byte_val[3:0];
          state_next = ppr_pkg::PP_CONF;
        end
      end
      ppr_pkg::PP_CONF:
      begin
        // R2: status captured as identify starts
        if (identify)
        begin
          latched_next = ist_s;
          state_next = ppr_pkg::PP_RESP;
        end
        else if (armed_reg && listen_addressed_i && is_ppe)
        begin
          assign_next = cmd_i.byte_val[3:0];
        end
      end
      ppr_pkg::PP_RESP:
      begin
        // R3: identify over, back to configured
        // R4: stays configured for the next identify
        if (!identify)
        begin
          state_next = ppr_pkg::PP_CONF;
        end
      end
      default:
      begin
        state_next = ppr_pkg::PP_IDLE;
      end
    endcase
    // R7: disable after configure, unconfigure or reset go idle
    if (clear_all || (armed_reg && listen_addressed_i && is_ppd))
    begin
      state_next = ppr_pkg::PP_IDLE;
      assign_next = ppr_pkg::ASSIGN_RESET;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_reg <= ppr_pkg::PP_IDLE;
      armed_reg <= 1'b0;
      assign_reg <= ppr_pkg::ASSIGN_RESET;
      latched_reg <= 1'b0;
    end
    else if (ce_i)
    begin
      state_reg <= state_next;
      armed_reg <= armed_next;
      assign_reg <= assign_next;
      latched_reg <= latched_next;
    end
  end

  // ----------------------------------------------------------------
  // Data line drive
  // ----------------------------------------------------------------
  logic [DIO_W-1:0] oe_reg;
  logic [DIO_W-1:0] oe_next;
  logic drive;
  // R11: drive only when latched status agrees with sense
  // R1: held for the whole identify, no handshake involved
  assign drive = (state_reg == ppr_pkg::PP_RESP) && identify && resp_en_reg &&
                 (latched_reg == assign_reg[ppr_pkg::SENSE_BIT]);

  // R3: all lines released unless driving
  always_comb
  begin
    oe_next = '0;
    if (drive)
    begin
      oe_next[assign_reg[2:0]] = 1'b1;
    end
  end

  // Registered so the pins never glitch between decode terms
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      oe_reg <= '0;
    end
    else if (ce_i)
    begin
      oe_reg <= oe_next;
    end
  end

  assign dio_oe_o = oe_reg;
  assign dio_o = '0; // Open drain: only ever pulls low

  // ----------------------------------------------------------------
  // Wishbone register file
  // ----------------------------------------------------------------
  logic ack_reg;
  logic ack_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic wr_ctrl;
  logic [31:0] status_word;

  // Write lands on the edge at which the master samples ack
  assign wr_ctrl = wb_cyc_i & wb_stb_i & wb_we_i & ack_reg &
                   (wb_adr_i == ppr_pkg::ADR_CTRL) & wb_sel_i[0];
  assign unconf_pulse = wr_ctrl & wb_dat_i[ppr_pkg::CTRL_UNCONF];
  // Status word for software reads
  always_comb
  begin
    status_word = '0;
    status_word[ppr_pkg::ST_ASSIGN_LSB +: 4] = assign_reg;
    status_word[ppr_pkg::ST_CONFIGURED] = (state_reg != ppr_pkg::PP_IDLE);
    status_word[ppr_pkg::ST_ARMED] = armed_reg;
    status_word[ppr_pkg::ST_RESPONDING] = |oe_reg;
    status_word[ppr_pkg::ST_LATCHED] = latched_reg;
  end

  // One wait state per access; unmapped reads give zero
  always_comb
  begin
    ack_next = wb_cyc_i & wb_stb_i & ~ack_reg;
    resp_en_next = resp_en_reg;
    rdata_next = rdata_reg;
    if (wr_ctrl)
    begin
      resp_en_next = wb_dat_i[ppr_pkg::CTRL_RESP_EN];
    end
    if (wb_cyc_i && wb_stb_i && !wb_we_i && !ack_reg)
    begin
      case (wb_adr_i)
        ppr_pkg::ADR_CTRL: rdata_next = {31'h0000_0000, resp_en_reg};
        ppr_pkg::ADR_STATUS: rdata_next = status_word;
        default: rdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ack_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      resp_en_reg <= ppr_pkg::CTRL_RESET[ppr_pkg::CTRL_RESP_EN];
    end
    else if (ce_i)
    begin
      ack_reg <= ack_next;
      rdata_reg <= rdata_next;
      resp_en_reg <= resp_en_next;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdata_reg;

endmodule
`default_nettype wire

/* verilog/ppr_pkg.sv */
`default_nettype none
package ppr_pkg;
  // Bus commands, as received from the acceptor logic
  localparam logic [7:0] CMD_PPC = 8'h05;
  localparam logic [7:0] CMD_PPU = 8'h15;
  localparam logic [7:0] CMD_UNL = 8'h3f;
  localparam logic [3:0] CMD_PPE_HI = 4'h6;
  localparam logic [3:0] CMD_PPD_HI = 4'h7;
  // Field positions inside an enable byte
  localparam int LINE_LSB = 0;
  localparam int SENSE_BIT = 3;
  // Register map (byte addresses)
  localparam logic [3:0] ADR_CTRL = 4'h0;
  localparam logic [3:0] ADR_STATUS = 4'h4;
  // Control register fields and reset value
  localparam int CTRL_RESP_EN = 0;
  localparam int CTRL_UNCONF = 1;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
  // Status register fields
  localparam int ST_ASSIGN_LSB = 0;
  localparam int ST_CONFIGURED = 4;
  localparam int ST_ARMED = 5;
  localparam int ST_RESPONDING = 6;
  localparam int ST_LATCHED = 7;
  localparam logic [3:0] ASSIGN_RESET = 4'h0;

  // Poll states, Gray order idle -> configured -> responding
  typedef enum logic [1:0] {
    PP_IDLE = 2'b00,
    PP_CONF = 2'b01,
    PP_RESP = 2'b11
  } ppr_state_e;

  // One received bus command
  typedef struct packed {
    logic valid;
    logic [7:0] byte_val;
  } ppr_cmd_s;
endpackage
`default_nettype wire

/* bench/ppr_asserts.sv */
`timescale 1ns/10ps
`default_nettype none
// ------------------
// Poll output and Wishbone ack checks
// ------------------
module ppr_asserts #(
  parameter int DIO_W = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic atn_n_i,
  input wire logic eoi_n_i,
  input wire logic master_reset_n_i,
  input wire logic [DIO_W-1:0] dio_o,
  input wire logic [DIO_W-1:0] dio_oe_o
);
  // Pin path is two sync flops plus the output register, so three edges
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire idy = !atn_n_i && !eoi_n_i;
  property p_one; $onehot0(dio_oe_o); endproperty
  a_one: assert property (p_one) else $error("two lines driven");
  property p_lvl; dio_o == '0; endproperty
  a_lvl: assert property (p_lvl) else $error("pull value not low");
  property p_src; |dio_oe_o |-> $past(idy, 3); endproperty
  a_src: assert property (p_src) else $error("drive without identify");
  property p_rel; $past(!idy, 3) |-> dio_oe_o == '0; endproperty
  a_rel: assert property (p_rel) else $error("line not released");
  property p_hold; $past(idy, 3) && $past(idy, 4) && $past(idy, 5) &&
    $past(master_reset_n_i, 4) |-> $stable(dio_oe_o); endproperty
  a_hold: assert property (p_hold) else $error("response moved in identify");
  property p_mr; (!master_reset_n_i)[*5] |-> dio_oe_o == '0; endproperty
  a_mr: assert property (p_mr) else $error("drive in master reset");
  property p_ans; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ans: assert property (p_ans) else $error("ack late");
  property p_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_pulse: assert property (p_pulse) else $error("ack too long");
endmodule
bind ppr_top ppr_asserts #(.DIO_W(DIO_W)) u_chk (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .atn_n_i(atn_n_i),
  .eoi_n_i(eoi_n_i), .master_reset_n_i(master_reset_n_i), .dio_o(dio_o), .dio_oe_o(dio_oe_o));
`default_nettype wire

/* bench/ppr_ctl_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ---------------------
// Bus controller model
// ---------------------
module ppr_ctl_model (
  input wire logic clk_i,
  output var ppr_pkg::ppr_cmd_s cmd_o,
  output var logic listen_o,
  output var logic atn_n_o,
  output var logic eoi_n_o
);
  // Lines idle passive high, as the bus pull-ups leave them
  initial
  begin
    cmd_o = '0;
    listen_o = 1'b0;
    atn_n_o = 1'b1;
    eoi_n_o = 1'b1;
  end
  task automatic send(input logic [7:0] b);
    @(posedge clk_i);
    cmd_o <= '{valid: 1'b1, byte_val: b};
    @(posedge clk_i);
    cmd_o <= '0;
  endtask
  // Identify is both lines together; no handshake involved
  task automatic idy(input logic on);
    @(posedge clk_i);
    atn_n_o <= !on;
    eoi_n_o <= !on;
  endtask
  task automatic listen(input logic on);
    @(posedge clk_i);
    listen_o <= on;
  endtask
endmodule
`default_nettype wire

/* bench/ppr_top_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module ppr_top_tb_top;
  logic clk_i = 0, rst_i = 1, mr_n = 1, instrument_status_bit = 0, cyc = 0, stb = 0, we = 0, ack;
  logic [3:0] adr = '0;
  logic [31:0] wdat = '0, rdat, r;
  logic [7:0] dio, oe, lf = 8'h49;
  logic atn_n, eoi_n, lsn;
  ppr_pkg::ppr_cmd_s cmd;
  int n_mismatch = 0, num_checks = 0, cyc_n = 0, m_arm = 0, m_conf = 0, m_line = 0;
  int m_sense = 0, m_en = 1;
  // bench supplies the one device clock
  always #5 clk_i = ~clk_i;
  ppr_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_ack_o(ack),
    .wb_dat_o(rdat), .cmd_i(cmd), .listen_addressed_i(lsn), .atn_n_i(atn_n),
    .eoi_n_i(eoi_n), .master_reset_n_i(mr_n), .instrument_status_bit_i(instrument_status_bit), .dio_o(dio),
    .dio_oe_o(oe));
  ppr_ctl_model u_ctl (.clk_i(clk_i), .cmd_o(cmd), .listen_o(lsn), .atn_n_o(atn_n),
    .eoi_n_o(eoi_n));
  // ------------------
  // Checking and tasks
  // ------------------
  task automatic results();
    if (n_mismatch == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Random source, eight-bit feedback register seeded at 73
  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  // Classic single cycle; held until ack is sampled
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do
      @(posedge clk_i);
    while (ack !== 1'b1);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
    wb(1'b0, a, '0);
    chk(r & m, e);
  endtask
  // Expected status from the model: assignment and configured flag
  task automatic rdst();
    rd(ppr_pkg::ADR_STATUS, 32'h1f, 32'(m_conf * 16 + m_sense * 8 + m_line));
  endtask
  task automatic clr();
    m_conf = 0;
    m_line = 0;
    m_sense = 0;
  endtask
  // Model follows every command the controller sends
  task automatic send(input logic [7:0] b);
    u_ctl.send(b);
    if (b == ppr_pkg::CMD_UNL)
      m_arm = 0;
    if (b == ppr_pkg::CMD_PPC && lsn)
      m_arm = 1;
    if (b == ppr_pkg::CMD_PPU || (b[7:4] == ppr_pkg::CMD_PPD_HI && m_arm != 0))
      clr();
    else if (b[7:4] == ppr_pkg::CMD_PPE_HI && m_arm != 0)
    begin
      m_conf = 1;
      m_line = int'(b[2:0]);
      m_sense = int'(b[3]);
    end
  endtask
  task automatic cfg();
    lf = lfsr(lf);
    send(ppr_pkg::CMD_PPC);
    send({ppr_pkg::CMD_PPE_HI, lf[3:0]});
  endtask
  // Status flips mid-identify; the latched value must win
  task automatic poll(input logic s);
    @(posedge clk_i);
    instrument_status_bit <= s;
    u_ctl.idy(1'b1);
    repeat (4) @(posedge clk_i);
    instrument_status_bit <= !s;
    repeat (5) @(posedge clk_i);
    chk({24'h0, oe}, (m_conf && m_en && s == m_sense) ? 32'h1 << m_line : '0);
    u_ctl.idy(1'b0);
    repeat (4) @(posedge clk_i);
    chk({24'h0, oe}, '0);
  endtask
  // Hang guard, far above the expected run
  always @(posedge clk_i)
  begin
    cyc_n++;
    if (cyc_n > 20000)
    begin
      n_mismatch++;
      results();
    end
  end
  // -------------
  // Main sequence
  // -------------
  initial
  begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(ppr_pkg::ADR_CTRL, '1, ppr_pkg::CTRL_RESET);
    rd(4'h8, '1, '0);
    rdst();
    poll(1'b0);
    u_ctl.listen(1'b1);
    send(8'h6b);
    rdst();
    cfg();
    send(ppr_pkg::CMD_UNL);
    send(8'h6e);
    rdst();
    for (int i = 0; i < 8; i++)
    begin
      lf = lfsr(lf);
      poll(lf[0]);
    end
    send(ppr_pkg::CMD_PPC);
    send(8'h70);
    rdst();
    poll(1'b0);
    cfg();
    rdst();
    poll(m_sense[0]);
    wb(1'b1, ppr_pkg::ADR_CTRL, '0);
    m_en = 0;
    poll(m_sense[0]);
    wb(1'b1, ppr_pkg::ADR_CTRL, 32'h1);
    m_en = 1;
    send(ppr_pkg::CMD_PPU);
    rdst();
    poll(1'b0);
    cfg();
    instrument_status_bit <= m_sense[0];
    u_ctl.idy(1'b1);
    repeat (6) @(posedge clk_i);
    chk({24'h0, oe}, 32'h1 << m_line);
    mr_n <= 1'b0;
    repeat (6) @(posedge clk_i);
    mr_n <= 1'b1;
    chk({24'h0, oe}, '0);
    clr();
    u_ctl.idy(1'b0);
    repeat (3) @(posedge clk_i);
    rdst();
    poll(1'b0);
    cfg();
    wb(1'b1, ppr_pkg::ADR_CTRL, 32'h3);
    clr();
    rdst();
    results();
  end
endmodule
`default_nettype wire
